//--- rtl/pms_consts.svh
// Timing figures, mode codes and command codes for the pack monitor sequencer
`ifndef PMS_CONSTS_SVH
`define PMS_CONSTS_SVH
`define PMS_CLK_KHZ 250000
`define PMS_ROUND_MS 1000
`define PMS_AUTOCAL_MS 5000
`define PMS_READY_US 1000
`define PMS_HIGH_TO_US 50
`define PMS_PU_US 100
`define PMS_OSC_TRY_US 250
`define PMS_ROUND_CYC (`PMS_ROUND_MS * `PMS_CLK_KHZ)
`define PMS_AUTOCAL_CYC (`PMS_AUTOCAL_MS * `PMS_CLK_KHZ)
`define PMS_READY_CYC ((`PMS_READY_US * `PMS_CLK_KHZ) / 1000)
`define PMS_HIGH_TO_CYC ((`PMS_HIGH_TO_US * `PMS_CLK_KHZ) / 1000)
`define PMS_PU_CYC ((`PMS_PU_US * `PMS_CLK_KHZ) / 1000)
`define PMS_OSC_TRY_CYC ((`PMS_OSC_TRY_US * `PMS_CLK_KHZ) / 1000)
`define PMS_MODE_NORMAL 2'h0
`define PMS_MODE_SLEEP 2'h1
`define PMS_MODE_SHUTDOWN 2'h2
`define PMS_CMD_CHG_CURRENT 8'h14
`define PMS_CMD_CHG_VOLTAGE 8'h15
`endif

//--- rtl/pms_pkg.sv
// Types of the pack monitor sequencer
package pms_pkg;
  typedef enum logic [1:0] {PMS_OSC_TRY, PMS_OSC_INT, PMS_OSC_XTAL} pms_osc_e;
  typedef enum logic [1:0] {PMS_SCAN_IDLE, PMS_SCAN_START, PMS_SCAN_WAIT} pms_scan_e;
endpackage

//--- rtl/pms_top.sv
// Pack monitor housekeeping sequencer: cadence, presence, bus idle, fuse, scan
//
// Notes on behaviour
// - Normal mode: one round every second
// - Sleep rounds at set interval; shutdown halts
// - Try internal oscillator, else use crystal
// - Pulse presence pull-up once per second
// - Sample presence only during pulse; low=present
// - Positive sense is charge, negative discharge
// - Accumulate sense samples continuously in counter
// - Each round scan cells, offset, reference
// - Autocalibrate after both lines low 5 s
// - Bus off after both lines low too long
// - Leave bus off on high; ready 1 ms
// - Secondary fault drives both fuse outputs
// - Bus master and error checking are options
// - Master broadcasts charging current and voltage
// - Clock high over 50 us aborts transaction
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.svh"
module pms_top
  import pms_pkg::*;
#(
  parameter int unsigned NCELL = 4,
  parameter int unsigned ROUND_CYC = `PMS_ROUND_CYC,
  parameter int unsigned AUTOCAL_CYC = `PMS_AUTOCAL_CYC,
  parameter int unsigned READY_CYC = `PMS_READY_CYC,
  parameter int unsigned HIGH_TO_CYC = `PMS_HIGH_TO_CYC,
  parameter int unsigned PU_CYC = `PMS_PU_CYC,
  parameter int unsigned OSC_TRY_CYC = `PMS_OSC_TRY_CYC
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic bus_clock_pin,
  input wire logic bus_data_pin,
  input wire logic system_present_in,
  input wire logic osc_timing_resistor_pin,
  input wire logic [1:0] power_mode,
  input wire logic [7:0] sleep_secs,
  input wire logic [31:0] off_period,
  input wire logic signed [15:0] sense_sample,
  input wire logic sense_valid,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  input wire logic [5:0] fault_in,
  input wire logic master_en,
  input wire logic pec_en,
  input wire logic [15:0] chg_current_req,
  input wire logic [15:0] chg_voltage_req,
  input wire logic bcast_ready,
  output logic round_start,
  output logic reduced_power,
  output logic osc_use_crystal,
  output logic osc_locked,
  output logic presence_pullup_drive,
  output logic system_present,
  output logic charge_active,
  output logic discharge_active,
  output logic [47:0] charge_count,
  output logic adc_start,
  output logic [3:0] afe_sel,
  output logic meas_valid,
  output logic [3:0] meas_sel,
  output logic [15:0] meas_data,
  output logic autocal_start,
  output logic bus_off,
  output logic bus_ready,
  output logic txn_abort,
  output logic fuse_drive_a,
  output logic fuse_drive_b,
  output logic bcast_valid,
  output logic [7:0] bcast_cmd,
  output logic [15:0] bcast_word,
  output logic bcast_pec,
  output logic rx_byte_valid,
  output logic [7:0] rx_byte
);
  localparam logic [3:0] OFS_SEL = 4'(NCELL);
  localparam logic [3:0] REF_SEL = 4'(NCELL + 1);

  // Parameters the counters and select field cannot hold
  if (NCELL < 1 || NCELL > 13 || PU_CYC < 2 || PU_CYC >= ROUND_CYC || READY_CYC < 2)
  begin : g_chk
    $error("pms_top: unsupported parameter values");
  end

  // Two-flop synchronisers for pins: clock, data, presence, resistor sense
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  assign pin_raw = {osc_timing_resistor_pin, system_present_in, bus_data_pin, bus_clock_pin};
  for (genvar i = 0; i < 4; i++)
  begin : g_sync
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        pin_s1_reg[i] <= 1'b0;
        pin_s2_reg[i] <= 1'b0;
      end
      else
      begin
        pin_s1_reg[i] <= pin_raw[i];
        pin_s2_reg[i] <= pin_s1_reg[i];
      end
    end
  end
  logic scl_s, sda_s, system_present_in_s, osc_timing_resistor_pin_s;
  assign {osc_timing_resistor_pin_s, system_present_in_s, sda_s, scl_s} = pin_s2_reg;

  // Link side: shift data on bus clock rises, toggle per full byte
  logic [7:0] lk_shift_reg, lk_shift_next, lk_byte_reg, lk_byte_next;
  logic [2:0] lk_bit_reg, lk_bit_next;
  logic lk_tgl_reg, lk_tgl_next;
  always_comb
  begin
    lk_shift_next = {lk_shift_reg[6:0], bus_data_pin};
    lk_bit_next = lk_bit_reg + 3'h1;
    lk_byte_next = lk_byte_reg;
    lk_tgl_next = lk_tgl_reg;
    if (lk_bit_reg == 3'h7)
    begin
      lk_byte_next = lk_shift_next;
      lk_tgl_next = ~lk_tgl_reg;
    end
  end
  always_ff @(posedge bus_clock_pin or negedge rstn)
  begin
    if (!rstn)
    begin
      lk_shift_reg <= 8'h00;
      lk_bit_reg <= 3'h0;
      lk_byte_reg <= 8'h00;
      lk_tgl_reg <= 1'b0;
    end
    else
    begin
      lk_shift_reg <= lk_shift_next;
      lk_bit_reg <= lk_bit_next;
      lk_byte_reg <= lk_byte_next;
      lk_tgl_reg <= lk_tgl_next;
    end
  end

  // Main domain state
  pms_osc_e osc_reg, osc_next;
  pms_scan_e scan_reg, scan_next;
  logic [31:0] osc_cnt_reg, osc_cnt_next, tick_cnt_reg, tick_cnt_next;
  logic [31:0] pu_cnt_reg, pu_cnt_next, idle_cnt_reg, idle_cnt_next;
  logic [31:0] rdy_cnt_reg, rdy_cnt_next, high_cnt_reg, high_cnt_next;
  logic [7:0] sleep_cnt_reg, sleep_cnt_next;
  logic [3:0] step_reg, step_next, msel_reg, msel_next;
  logic [15:0] ofs_reg, ofs_next, mdata_reg, mdata_next, bword_reg, bword_next;
  logic [47:0] acc_reg, acc_next;
  logic [2:0] tg_reg, tg_next;
  logic [7:0] rx_reg, rx_next, bcmd_reg, bcmd_next;
  logic round_reg, round_next, pu_reg, pu_next, system_present_in_reg, system_present_in_next;
  logic chg_reg, chg_next, dis_reg, dis_next, mval_reg, mval_next;
  logic cal_reg, cal_next, off_reg, off_next, rdy_reg, rdy_next;
  logic abort_reg, abort_next, fuse_reg, fuse_next, rxv_reg, rxv_next;
  logic bval_reg, bval_next, bsecond_reg, bsecond_next;
  logic sec_tick, pu_end, run, both_low;

  // Oscillator selection, second cadence, presence pulse, round start
  always_comb
  begin
    osc_next = osc_reg;
    osc_cnt_next = osc_cnt_reg;
    if (osc_reg == PMS_OSC_TRY)
    begin
      osc_cnt_next = osc_cnt_reg + 32'h0000_0001;
      if (osc_cnt_reg == 32'(OSC_TRY_CYC - 1))
        osc_next = osc_timing_resistor_pin_s ? PMS_OSC_INT : PMS_OSC_XTAL;
    end
    run = (osc_reg != PMS_OSC_TRY) && (power_mode != `PMS_MODE_SHUTDOWN);
    sec_tick = run && (tick_cnt_reg == 32'(ROUND_CYC - 1));
    tick_cnt_next = (!run || sec_tick) ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    // Sleep mode waits sleep_secs ticks; zero is taken as one
    sleep_cnt_next = sleep_cnt_reg;
    round_next = 1'b0;
    if (sec_tick && power_mode == `PMS_MODE_NORMAL)
      round_next = 1'b1;
    else if (sec_tick && power_mode == `PMS_MODE_SLEEP)
    begin
      sleep_cnt_next = sleep_cnt_reg + 8'h01;
      if (sleep_cnt_reg + 8'h01 >= sleep_secs)
      begin
        round_next = 1'b1;
        sleep_cnt_next = 8'h00;
      end
    end
    pu_end = pu_reg && (pu_cnt_reg == 32'(PU_CYC - 1));
    pu_next = (pu_reg && !pu_end) || sec_tick;
    pu_cnt_next = pu_reg ? pu_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    system_present_in_next = pu_end ? !system_present_in_s : system_present_in_reg;
  end

  // Sense polarity and charge accumulation
  always_comb
  begin
    chg_next = chg_reg;
    dis_next = dis_reg;
    acc_next = acc_reg;
    if (sense_valid)
    begin
      chg_next = sense_sample > 16'sh0000;
      dis_next = sense_sample < 16'sh0000;
      acc_next = acc_reg + {{32{sense_sample[15]}}, sense_sample};
    end
  end

  // Cell scan: offset first so cells are corrected by a fresh offset
  always_comb
  begin
    scan_next = scan_reg;
    step_next = step_reg;
    ofs_next = ofs_reg;
    mdata_next = mdata_reg;
    msel_next = msel_reg;
    mval_next = 1'b0;
    unique case (scan_reg)
      PMS_SCAN_IDLE:
        if (round_reg)
        begin
          step_next = OFS_SEL;
          scan_next = PMS_SCAN_START;
        end
      PMS_SCAN_START:
        scan_next = PMS_SCAN_WAIT;
      PMS_SCAN_WAIT:
        if (adc_done)
        begin
          mval_next = 1'b1;
          msel_next = step_reg;
          mdata_next = adc_data - ofs_reg;
          if (step_reg == OFS_SEL)
          begin
            ofs_next = adc_data;
            mdata_next = adc_data;
          end
          scan_next = PMS_SCAN_START;
          if (step_reg == OFS_SEL)
            step_next = REF_SEL;
          else if (step_reg == REF_SEL)
            step_next = 4'h0;
          else
            step_next = step_reg + 4'h1;
          if (step_reg == OFS_SEL - 4'h1)
            scan_next = PMS_SCAN_IDLE;
        end
    endcase
  end

  // Bus idle-low timing, off state, ready delay, clock-high abort
  always_comb
  begin
    both_low = !scl_s && !sda_s;
    idle_cnt_next = both_low ? idle_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    if (idle_cnt_reg == 32'hFFFF_FFFF)
      idle_cnt_next = idle_cnt_reg;
    cal_next = both_low && (idle_cnt_reg == 32'(AUTOCAL_CYC - 1));
    off_next = off_reg;
    if (both_low && idle_cnt_reg >= off_period)
      off_next = 1'b1;
    else if (!both_low)
      off_next = 1'b0;
    rdy_cnt_next = 32'h0000_0000;
    rdy_next = rdy_reg;
    if (off_next)
      rdy_next = 1'b0;
    else if (!rdy_reg)
    begin
      rdy_cnt_next = rdy_cnt_reg + 32'h0000_0001;
      rdy_next = rdy_cnt_reg == 32'(READY_CYC - 1);
    end
    high_cnt_next = scl_s ? high_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
    if (high_cnt_reg == 32'hFFFF_FFFF)
      high_cnt_next = high_cnt_reg;
    abort_next = scl_s && (high_cnt_reg == 32'(HIGH_TO_CYC));
    fuse_next = fuse_reg || (|fault_in);
    tg_next = {tg_reg[1:0], lk_tgl_reg};
    rxv_next = tg_reg[2] ^ tg_reg[1];
    rx_next = (tg_reg[2] ^ tg_reg[1]) ? lk_byte_reg : rx_reg;
  end

  // Charger broadcasts: current word then voltage word per round
  always_comb
  begin
    bval_next = bval_reg;
    bsecond_next = bsecond_reg;
    bcmd_next = bcmd_reg;
    bword_next = bword_reg;
    if (bval_reg && bcast_ready)
    begin
      bval_next = bsecond_reg;
      bsecond_next = 1'b0;
      bcmd_next = `PMS_CMD_CHG_VOLTAGE;
      bword_next = chg_voltage_req;
    end
    else if (!bval_reg && round_reg && master_en && rdy_reg)
    begin
      bval_next = 1'b1;
      bsecond_next = 1'b1;
      bcmd_next = `PMS_CMD_CHG_CURRENT;
      bword_next = chg_current_req;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      osc_reg <= PMS_OSC_TRY;
      scan_reg <= PMS_SCAN_IDLE;
      {osc_cnt_reg, tick_cnt_reg, pu_cnt_reg} <= 96'h0;
      {idle_cnt_reg, rdy_cnt_reg, high_cnt_reg} <= 96'h0;
      {sleep_cnt_reg, step_reg, msel_reg} <= 16'h0000;
      {ofs_reg, mdata_reg, bword_reg} <= 48'h0;
      acc_reg <= 48'h0;
      {tg_reg, rx_reg, bcmd_reg} <= 19'h0_0000;
      {round_reg, pu_reg, system_present_in_reg, chg_reg, dis_reg, mval_reg} <= 6'h00;
      {cal_reg, off_reg, rdy_reg, abort_reg, fuse_reg, rxv_reg} <= 6'h00;
      {bval_reg, bsecond_reg} <= 2'h0;
    end
    else
    begin
      osc_reg <= osc_next;
      scan_reg <= scan_next;
      {osc_cnt_reg, tick_cnt_reg, pu_cnt_reg} <= {osc_cnt_next, tick_cnt_next, pu_cnt_next};
      {idle_cnt_reg, rdy_cnt_reg, high_cnt_reg} <= {idle_cnt_next, rdy_cnt_next, high_cnt_next};
      {sleep_cnt_reg, step_reg, msel_reg} <= {sleep_cnt_next, step_next, msel_next};
      {ofs_reg, mdata_reg, bword_reg} <= {ofs_next, mdata_next, bword_next};
      acc_reg <= acc_next;
      {tg_reg, rx_reg, bcmd_reg} <= {tg_next, rx_next, bcmd_next};
      {round_reg, pu_reg, system_present_in_reg} <= {round_next, pu_next, system_present_in_next};
      {chg_reg, dis_reg, mval_reg} <= {chg_next, dis_next, mval_next};
      {cal_reg, off_reg, rdy_reg} <= {cal_next, off_next, rdy_next};
      {abort_reg, fuse_reg, rxv_reg} <= {abort_next, fuse_next, rxv_next};
      {bval_reg, bsecond_reg} <= {bval_next, bsecond_next};
    end
  end

  // Outputs
  assign round_start = round_reg;
  assign reduced_power = run && (scan_reg == PMS_SCAN_IDLE);
  assign osc_use_crystal = osc_reg == PMS_OSC_XTAL;
  assign osc_locked = osc_reg != PMS_OSC_TRY;
  assign presence_pullup_drive = pu_reg;
  assign system_present = system_present_in_reg;
  assign {charge_active, discharge_active, charge_count} = {chg_reg, dis_reg, acc_reg};
  assign adc_start = scan_reg == PMS_SCAN_START;
  assign afe_sel = step_reg;
  assign {meas_valid, meas_sel, meas_data} = {mval_reg, msel_reg, mdata_reg};
  assign {autocal_start, bus_off, bus_ready, txn_abort} = {cal_reg, off_reg, rdy_reg, abort_reg};
  assign fuse_drive_a = fuse_reg;
  assign fuse_drive_b = fuse_reg;
  assign {bcast_valid, bcast_cmd, bcast_word} = {bval_reg, bcmd_reg, bword_reg};
  assign bcast_pec = pec_en;
  assign {rx_byte_valid, rx_byte} = {rxv_reg, rx_reg};

  // Checks
  sequence s_round_kick;
    round_reg && scan_reg == PMS_SCAN_IDLE;
  endsequence
  sequence s_offset_first;
    adc_start && afe_sel == OFS_SEL;
  endsequence
  round_gap_a: assert property (@(posedge clk) disable iff (!rstn)
    round_reg && power_mode == `PMS_MODE_NORMAL |-> tick_cnt_reg == 32'h0000_0000)
    else $error("round not aligned to second tick");
  shutdown_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
    power_mode == `PMS_MODE_SHUTDOWN ##1 power_mode == `PMS_MODE_SHUTDOWN |=> !round_reg)
    else $error("round during shutdown");
  osc_pick_a: assert property (@(posedge clk) disable iff (!rstn)
    osc_reg == PMS_OSC_TRY && osc_cnt_reg == 32'(OSC_TRY_CYC - 1) |=> osc_use_crystal == !$past(osc_timing_resistor_pin_s))
    else $error("wrong oscillator choice");
  pu_width_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pu_reg) |-> $past(pu_cnt_reg) == 32'(PU_CYC - 1))
    else $error("pull-up pulse width wrong");
  system_present_in_sample_a: assert property (@(posedge clk) disable iff (!rstn)
    pu_end |=> system_present == !$past(system_present_in_s))
    else $error("presence sample wrong");
  system_present_in_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    !pu_end |=> $stable(system_present))
    else $error("presence changed outside pulse");
  sense_dir_a: assert property (@(posedge clk) disable iff (!rstn)
    sense_valid |=> charge_active == ($past(sense_sample) > 16'sh0000) && !(charge_active && discharge_active))
    else $error("sense polarity wrong");
  acc_step_a: assert property (@(posedge clk) disable iff (!rstn)
    sense_valid |=> charge_count == $past(charge_count) + {{32{$past(sense_sample[15])}}, $past(sense_sample)})
    else $error("charge count step wrong");
  scan_order_a: assert property (@(posedge clk) disable iff (!rstn)
    s_round_kick |=> s_offset_first)
    else $error("scan did not start at offset");
  autocal_a: assert property (@(posedge clk) disable iff (!rstn)
    autocal_start |-> $past(idle_cnt_reg) == 32'(AUTOCAL_CYC - 1) && $past(both_low))
    else $error("autocal without idle time");
  idle_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    !both_low |=> idle_cnt_reg == 32'h0000_0000 && !bus_off)
    else $error("idle timer or off state not cleared");
  ready_delay_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(bus_ready) |-> $past(rdy_cnt_reg) == 32'(READY_CYC - 1) && !bus_off)
    else $error("bus ready timing wrong");
  fuse_a: assert property (@(posedge clk) disable iff (!rstn)
    |fault_in |=> fuse_drive_a && fuse_drive_b ##1 fuse_drive_a && fuse_drive_b)
    else $error("fuse drive missing");
  abort_a: assert property (@(posedge clk) disable iff (!rstn)
    txn_abort |-> $past(scl_s) && $past(high_cnt_reg) == 32'(HIGH_TO_CYC))
    else $error("abort without clock-high timeout");
  bcast_a: assert property (@(posedge clk) disable iff (!rstn)
    bcast_valid && bcast_ready && bcast_cmd == `PMS_CMD_CHG_CURRENT |=> bcast_valid && bcast_cmd == `PMS_CMD_CHG_VOLTAGE)
    else $error("voltage broadcast missing");
endmodule
`default_nettype wire

//--- tb/pms_host_model.sv
// SMBus host and smart charger stand-in facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pms_host_model (
  input wire logic clk,
  input wire logic bcast_valid,
  output var logic bus_clock_pin,
  output var logic bus_data_pin,
  output var logic bcast_ready
);
  int stall = 1;

  // Lines idle high through the pull-ups; the clock stands still between frames
  initial
  begin
    bus_clock_pin = 1'b1;
    bus_data_pin = 1'b1;
    bcast_ready = 1'b0;
  end

  // One byte, top bit first, data moved while the clock is low
  task automatic send_byte(input logic [7:0] b);
    #5.3;
    for (int i = 7; i >= 0; i--)
    begin
      bus_clock_pin = 1'b0;
      bus_data_pin = b[i];
      #24;
      bus_clock_pin = 1'b1;
      #24;
    end
    bus_data_pin = 1'b1;
  endtask

  // Both lines pulled low, as when the pack leaves the system
  task automatic hold_low();
    @(negedge clk);
    bus_clock_pin = 1'b0;
    bus_data_pin = 1'b0;
  endtask

  task automatic release_bus();
    @(negedge clk);
    bus_clock_pin = 1'b1;
    bus_data_pin = 1'b1;
  endtask

  // Charger takes each word after a stall of one to four cycles
  always @(negedge clk)
  begin
    if (bcast_valid === 1'b1 && !bcast_ready && stall <= 1)
    begin
      bcast_ready <= 1'b1;
      stall <= $urandom_range(4, 1);
    end
    else
    begin
      bcast_ready <= 1'b0;
      if (bcast_valid === 1'b1 && !bcast_ready)
        stall <= stall - 1;
    end
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the pack monitor sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int NC = 4;
  localparam int RC = 2000;
  logic clk = 1'b0;
  logic rstn = 1'b1; // Dropped by do_reset so the link flops see a reset edge
  logic bus_clock_pin, bus_data_pin, bcast_ready;
  logic system_present_in = 1'b1;
  logic osc_timing_resistor_pin = 1'b1;
  logic [1:0] power_mode = 2'h0;
  logic [7:0] sleep_secs = 8'h01;
  logic [31:0] off_period = 32'h0000_012c;
  logic signed [15:0] sense_sample = 16'sh0000;
  logic sense_valid = 1'b0;
  logic adc_done = 1'b0;
  logic [15:0] adc_data = 16'h0000;
  logic [5:0] fault_in = 6'h00;
  logic master_en = 1'b1;
  logic pec_en = 1'b0;
  logic [15:0] chg_current_req = 16'h0000;
  logic [15:0] chg_voltage_req = 16'h0000;
  logic round_start, reduced_power, osc_use_crystal, osc_locked, presence_pullup_drive;
  logic system_present, charge_active, discharge_active, adc_start, meas_valid;
  logic autocal_start, bus_off, bus_ready, txn_abort, fuse_drive_a, fuse_drive_b;
  logic bcast_valid, bcast_pec, rx_byte_valid;
  logic [47:0] charge_count;
  logic [3:0] afe_sel, meas_sel;
  logic [15:0] meas_data, bcast_word;
  logic [7:0] bcast_cmd, rx_byte;
  int n_mismatch = 0;
  int check_count = 0;
  int pos = 0;
  int n_autocal = 0;
  logic [15:0] offs = 16'h0000;
  logic signed [47:0] acc = 48'sh0000_0000_0000;

  always #2 clk = ~clk;

  // Long counts shortened so a run stays in the tens of thousands of cycles
  pms_top #(.NCELL(NC), .ROUND_CYC(RC), .AUTOCAL_CYC(500), .READY_CYC(50),
    .HIGH_TO_CYC(40), .PU_CYC(20), .OSC_TRY_CYC(10)) i_dut (.clk, .rstn,
    .bus_clock_pin, .bus_data_pin, .system_present_in, .osc_timing_resistor_pin,
    .power_mode, .sleep_secs, .off_period, .sense_sample, .sense_valid, .adc_done,
    .adc_data, .fault_in, .master_en, .pec_en, .chg_current_req, .chg_voltage_req,
    .bcast_ready, .round_start, .reduced_power, .osc_use_crystal, .osc_locked,
    .presence_pullup_drive, .system_present, .charge_active, .discharge_active,
    .charge_count, .adc_start, .afe_sel, .meas_valid, .meas_sel, .meas_data,
    .autocal_start, .bus_off, .bus_ready, .txn_abort, .fuse_drive_a, .fuse_drive_b,
    .bcast_valid, .bcast_cmd, .bcast_word, .bcast_pec, .rx_byte_valid, .rx_byte);

  pms_host_model i_host (.clk, .bcast_valid, .bus_clock_pin, .bus_data_pin, .bcast_ready);

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic pick(input int k);
    case (k)
      0: return round_start;
      1: return osc_locked;
      4: return autocal_start;
      5: return bus_off;
      6: return bus_ready;
      7: return txn_abort;
      8: return rx_byte_valid;
      11: return bcast_cmd !== 8'h14;
      12: return !bcast_valid;
      default: return !bus_off;
    endcase
  endfunction

  // Bounded wait for a flag of the design; n gives the cycles spent
  task automatic wait_hi(input int k, input int lim, output int n);
    n = 0;
    while (pick(k) !== 1'b1)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        n_mismatch++;
        $display("CHECK FAILED wait %0d expected 1 seen 0", k);
        results();
      end
    end
  endtask

  // Spacing between two later rounds, skipping the one in flight
  task automatic round_gap(input int exp);
    int n;
    @(posedge clk);
    #1;
    wait_hi(0, exp + 9, n);
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end while (round_start !== 1'b1 && n < exp + 9);
    check("round gap", n, exp);
  endtask

  task automatic do_reset();
    int n;
    @(negedge clk);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    wait_hi(1, 40, n);
    check("crystal", osc_use_crystal, !osc_timing_resistor_pin);
  endtask

  // Front-end stand-in: answers each conversion after a stall, checks the result
  initial
  begin
    logic [15:0] raw;
    int sel;
    forever
    begin
      // Mid-cycle look: the next start stands in the same cycle as meas_valid
      @(negedge clk);
      if (rstn !== 1'b1)
        pos = 0;
      while (rstn === 1'b1 && adc_start === 1'b1)
      begin
        sel = pos == 0 ? NC : pos == 1 ? NC + 1 : pos - 2;
        check("afe_sel", afe_sel, sel);
        raw = 16'($urandom);
        repeat ($urandom_range(4, 1)) @(negedge clk);
        adc_data = raw;
        adc_done = 1'b1;
        @(negedge clk);
        adc_done = 1'b0;
        if (sel == NC)
          offs = raw;
        check("meas_valid", meas_valid, 1'b1);
        check("meas_sel", meas_sel, sel);
        check("meas_data", meas_data, sel == NC ? raw : 16'(raw - offs));
        pos = (pos + 1) % (NC + 2);
      end
    end
  end

  always @(posedge clk) if (autocal_start === 1'b1) n_autocal++;

  initial
  begin
    int n;
    logic signed [15:0] s;
    logic [7:0] b;
    n = $urandom(87);
    do_reset();
    // Link bytes, each checked once the received-byte flag rises
    repeat (3)
    begin
      b = 8'($urandom);
      fork
        i_host.send_byte(b);
        wait_hi(8, 150, n);
      join
      check("rx_byte", rx_byte, b);
    end
    $display("link test done");
    // Signed sense samples, both directions
    repeat (24)
    begin
      s = 16'($urandom_range(3000, 1));
      if ($urandom_range(1, 0) == 1)
        s = -s;
      @(negedge clk);
      sense_sample = s;
      sense_valid = 1'b1;
      @(negedge clk);
      sense_valid = 1'b0;
      acc = acc + s;
      check("charge", charge_active, s > 0);
      check("discharge", discharge_active, s < 0);
      check("count", charge_count, acc);
    end
    $display("sense test done");
    @(negedge clk);
    system_present_in = 1'b0;
    wait_hi(0, RC + 50, n);
    check("pullup", presence_pullup_drive, 1'b1);
    repeat (30) @(negedge clk);
    check("pullup end", presence_pullup_drive, 1'b0);
    check("present", system_present, 1'b1);
    system_present_in = 1'b1;
    repeat (200) @(negedge clk);
    check("present held", system_present, 1'b1);
    check("quiet", reduced_power, 1'b1);
    round_gap(RC);
    check("absent", system_present, 1'b0);
    $display("round test done");
    // Broadcasts with and without error checking, then with master mode off
    for (int k = 0; k < 3; k++)
    begin
      @(negedge clk);
      pec_en = k[0];
      master_en = k < 2;
      chg_current_req = 16'($urandom);
      chg_voltage_req = 16'($urandom);
      wait_hi(0, RC + 9, n);
      @(posedge clk);
      #1;
      check("bcast valid", bcast_valid, master_en);
      check("bcast pec", bcast_pec, pec_en);
      if (k < 2)
      begin
        check("cmd current", {bcast_cmd, bcast_word}, {8'h14, chg_current_req});
        wait_hi(11, 9, n);
        check("cmd voltage", {bcast_cmd, bcast_word}, {8'h15, chg_voltage_req});
        wait_hi(12, 9, n);
      end
    end
    $display("broadcast test done");
    n_autocal = 0;
    i_host.hold_low();
    wait_hi(5, 400, n);
    check("off delay", n inside {[297:307]}, 1'b1);
    check("ready off", bus_ready, 1'b0);
    i_host.release_bus();
    wait_hi(10, 9, n);
    wait_hi(6, 70, n);
    check("ready delay", n inside {[47:55]}, 1'b1);
    check("no autocal", n_autocal, 0);
    i_host.hold_low();
    wait_hi(4, 600, n);
    check("autocal delay", n inside {[495:508]}, 1'b1);
    i_host.release_bus();
    wait_hi(7, 60, n);
    check("abort delay", n inside {[38:46]}, 1'b1);
    $display("bus idle test done");
    @(negedge clk);
    power_mode = 2'h1;
    sleep_secs = 8'h02;
    wait_hi(0, 5 * RC, n);
    round_gap(2 * RC);
    @(negedge clk);
    power_mode = 2'h2;
    repeat (100) @(negedge clk);
    n = 0;
    repeat (5000)
    begin
      @(posedge clk);
      #1;
      if (round_start !== 1'b0 || presence_pullup_drive !== 1'b0)
        n++;
    end
    check("shutdown", n, 0);
    $display("mode test done");
    @(negedge clk);
    osc_timing_resistor_pin = 1'b0;
    for (int k = 0; k < 6; k++)
    begin
      do_reset();
      check("fuse clear", {fuse_drive_a, fuse_drive_b}, 2'h0);
      @(negedge clk);
      fault_in = 6'(1 << k);
      @(negedge clk);
      fault_in = 6'h00;
      check("fuse", {fuse_drive_a, fuse_drive_b}, 2'h3);
      repeat (3) @(negedge clk);
      check("fuse held", {fuse_drive_a, fuse_drive_b}, 2'h3);
    end
    $display("fuse test done");
    results();
  end
endmodule
`default_nettype wire
